// [design/input_capture_unit.sv]
// Purpose: Two-channel input capture with four-entry buffers and interrupts.
// Assumes: Single 100 MHz clock; capture pins are asynchronous.
// Notes: Wishbone ack comes one cycle after the request is seen.
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - A qualifying pin event stores the selected 16-bit timer count.
// - Falling mode captures on each high-to-low pin transition.
// - Rising mode captures on each low-to-high pin transition.
// - Both-edges mode captures on every pin transition.
// - Divide-by-four mode captures on every fourth rising edge.
// - Divide-by-sixteen mode captures on every sixteenth rising edge.
// - Two independent channels, each with pin, mode, buffer, interrupt.
// - Each channel selects time base a or b as source.
// - Timer clock source does not change capture behaviour.
// - Pin edges on channels not set to off raise a wake request during sleep or idle.
// - Capture events can raise a channel interrupt request.
// - Each channel buffers four 16-bit values first in first out.
// - Interrupt raised once one to four entries are occupied.
// - Channels serve as plain external interrupt inputs via edge detection.
module input_capture_unit
  import capture_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_CH-1:0] capture_input_pin_i,
  input wire logic [TIMER_W-1:0] time_base_a_i,
  input wire logic [TIMER_W-1:0] time_base_b_i,
  input wire logic low_power_i,
  output logic wake_o,
  output logic irq_o
);
  wb_req_t req;
  logic access;
  logic wr;
  logic rd;
  ch_ctrl_t ctrl [NUM_CH];
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_set;
  logic [NUM_CH-1:0] pop;
  logic [NUM_CH-1:0] ev_any;
  logic [CNT_W-1:0] count [NUM_CH];
  logic [TIMER_W-1:0] head [NUM_CH];
  logic [NUM_CH-1:0] overflow;
  logic [NUM_CH-1:0] thr_hit;
  logic [31:0] next_rdata;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};
  // A request is taken only while ack is low, so a held strobe is not taken twice.
  assign access = req.cyc && req.stb && !wb_ack_o;
  assign wr = access && req.we;
  assign rd = access && !req.we;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction

  // Control word layout: mode in the low bits, timer select and threshold above.
  function automatic ch_ctrl_t ctrl_from_word(input logic [31:0] word);
    ch_ctrl_t fields;
    fields.mode = cap_mode_t'(word[CTRL_MODE_LSB+:$bits(fields.mode)]);
    fields.tsel = word[CTRL_TSEL_BIT];
    fields.thr = word[CTRL_THR_LSB+:$bits(fields.thr)];
    return fields;
  endfunction

  function automatic logic [31:0] ctrl_to_word(input ch_ctrl_t fields);
    logic [31:0] word;
    word = READ_ZERO;
    word[CTRL_MODE_LSB+:$bits(fields.mode)] = fields.mode;
    word[CTRL_TSEL_BIT] = fields.tsel;
    word[CTRL_THR_LSB+:$bits(fields.thr)] = fields.thr;
    return word;
  endfunction

  // Ack is a single-cycle pulse one clock after the request is taken.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
    end
  end

  // Control registers, byte lane zero only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl[0] <= '{thr: 2'b00, tsel: 1'b0, mode: MODE_OFF};
      ctrl[1] <= '{thr: 2'b00, tsel: 1'b0, mode: MODE_OFF};
    end else if (wr && req.sel[0]) begin
      if (hit(req.adr, REG_CTRL0)) begin
        ctrl[0] <= ctrl_from_word(req.dat);
      end
      if (hit(req.adr, REG_CTRL1)) begin
        ctrl[1] <= ctrl_from_word(req.dat);
      end
    end
  end

  // Mask bits share the status layout; only byte lane zero is written.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= '0;
    end else if (wr && req.sel[0] && hit(req.adr, REG_IRQ_MASK)) begin
      irq_mask <= req.dat[IRQ_W-1:0];
    end
  end

  // Set wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= '0;
    end else if (wr && req.sel[0] && hit(req.adr, REG_IRQ_STATUS)) begin
      irq_status <= (irq_status & ~req.dat[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  assign irq_set = {overflow, thr_hit};
  assign irq_o = |(irq_status & irq_mask);

  assign pop[0] = rd && hit(req.adr, REG_DATA0);
  assign pop[1] = rd && hit(req.adr, REG_DATA1);

  // Read data is chosen from the address and loaded only when a read is taken.
  always_comb begin
    next_rdata = READ_ZERO;
    unique case (req.adr)
      REG_CTRL0: next_rdata = ctrl_to_word(ctrl[0]);
      REG_CTRL1: next_rdata = ctrl_to_word(ctrl[1]);
      REG_DATA0: next_rdata[TIMER_W-1:0] = head[0];
      REG_DATA1: next_rdata[TIMER_W-1:0] = head[1];
      REG_LEVEL: begin
        next_rdata[CNT_W-1:0] = count[0];
        next_rdata[LEVEL_CH1_LSB+:CNT_W] = count[1];
      end
      REG_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
      REG_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
      default: next_rdata = READ_ZERO;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= READ_ZERO;
    end else if (rd) begin
      wb_dat_o <= next_rdata;
    end
  end

  // Wake request follows any pin edge on a channel not set to off while the processor is asleep.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= low_power_i && |ev_any;
    end
  end

  // One channel per generate pass.
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      logic sync_a;
      logic sync_b;
      logic pin_q;
      logic pin_valid;
      logic rise;
      logic fall;
      logic [PRESC_W-1:0] presc;
      cap_mode_t mode_q;
      logic mode_chg;
      logic capture;
      logic [TIMER_W-1:0] stamp;
      logic [TIMER_W-1:0] mem [FIFO_DEPTH];
      logic [PTR_W-1:0] wptr;
      logic [PTR_W-1:0] rptr;
      logic do_pop;
      logic do_push;
      logic [CNT_W-1:0] next_count;

      // Two flops meet the asynchronous pin; the third copy is the previous level.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync_a <= 1'b0;
          sync_b <= 1'b0;
          pin_q <= 1'b0;
          pin_valid <= 1'b0;
        end else begin
          sync_a <= capture_input_pin_i[c];
          sync_b <= sync_a;
          pin_q <= sync_b;
          pin_valid <= 1'b1;
        end
      end

      assign rise = pin_valid && sync_b && !pin_q;
      assign fall = pin_valid && !sync_b && pin_q;
      // Captures are skipped in the cycle after a write that changes the mode, while the prescaler restarts; wake still sees edges.
      assign mode_chg = (mode_q != ctrl[c].mode);
      assign ev_any[c] = (ctrl[c].mode != MODE_OFF) && (rise || fall);

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          mode_q <= MODE_OFF;
        end else begin
          mode_q <= ctrl[c].mode;
        end
      end

      // Rising edges are counted from the mode write for the divided modes.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          presc <= PRESC_ZERO;
        end else if (mode_chg) begin
          presc <= PRESC_ZERO;
        end else if (rise) begin
          presc <= presc + 4'h1;
        end
      end

      always_comb begin
        capture = 1'b0;
        if (!mode_chg) begin
          unique case (ctrl[c].mode)
            MODE_FALL: capture = fall;
            MODE_RISE: capture = rise;
            MODE_BOTH: capture = rise || fall;
            MODE_DIV4: capture = rise && (presc[1:0] == PRESC_DIV4_LAST[1:0]);
            MODE_DIV16: capture = rise && (presc == PRESC_DIV16_LAST);
            default: capture = 1'b0;
          endcase
        end
      end

      // Timer values are same-clock counts whatever drives them.
      assign stamp = ctrl[c].tsel ? time_base_b_i : time_base_a_i;
      assign do_pop = pop[c] && (count[c] != '0);
      assign do_push = capture && (count[c] != CNT_FULL || do_pop);
      // A capture into a full buffer with no read in the same cycle is dropped and flagged.
      assign overflow[c] = capture && !do_push;
      // The oldest entry is always visible, so a read returns it and pops in one cycle.
      assign head[c] = mem[rptr];

      // Occupancy after this cycle's push and pop; both together leave it unchanged.
      always_comb begin
        next_count = count[c];
        if (do_push && !do_pop) begin
          next_count = count[c] + 3'h1;
        end else if (do_pop && !do_push) begin
          next_count = count[c] - 3'h1;
        end
      end

      // Request once occupancy reaches the chosen level on a capture.
      assign thr_hit[c] = do_push && (next_count == {1'b0, ctrl[c].thr} + 3'h1);

      // Entries start at zero so a read of an empty buffer returns no unknowns.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          for (int e = 0; e < FIFO_DEPTH; e++) begin
            mem[e] <= '0;
          end
        end else if (do_push) begin
          mem[wptr] <= stamp;
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          wptr <= '0;
        end else begin
          wptr <= wptr + {1'b0, do_push};
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          rptr <= '0;
        end else begin
          rptr <= rptr + {1'b0, do_pop};
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          count[c] <= '0;
        end else begin
          count[c] <= next_count;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// [design/capture_pkg.sv]
// Purpose: Shared constants and types for the input capture unit.
// Assumes: Classic Wishbone slave with 32-bit data, word-aligned registers.
// Notes: Register offsets are byte addresses.
package capture_pkg;
  localparam int NUM_CH = 2;
  localparam int TIMER_W = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int PTR_W = 2;
  localparam int CNT_W = 3;
  localparam int PRESC_W = 4;

  localparam logic [7:0] REG_CTRL0 = 8'h00;
  localparam logic [7:0] REG_CTRL1 = 8'h04;
  localparam logic [7:0] REG_DATA0 = 8'h08;
  localparam logic [7:0] REG_DATA1 = 8'h0C;
  localparam logic [7:0] REG_LEVEL = 8'h10;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;

  // Control, level and interrupt register field positions.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_TSEL_BIT = 4;
  localparam int CTRL_THR_LSB = 5;
  localparam int LEVEL_CH1_LSB = 8;
  localparam int IRQ_OVF_LSB = 2;
  localparam int IRQ_W = 4;

  localparam logic [PRESC_W-1:0] PRESC_DIV4_LAST = 4'h3;
  localparam logic [PRESC_W-1:0] PRESC_DIV16_LAST = 4'hF;
  localparam logic [PRESC_W-1:0] PRESC_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_FULL = 3'h4;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_FALL = 3'h1,
    MODE_RISE = 3'h2,
    MODE_BOTH = 3'h3,
    MODE_DIV4 = 3'h4,
    MODE_DIV16 = 3'h5
  } cap_mode_t;

  typedef struct packed {
    logic [1:0] thr;
    logic tsel;
    cap_mode_t mode;
  } ch_ctrl_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_t;
endpackage

// [bench/icu_props.sv]
// Purpose: Port checks for the capture unit.
// Assumes: One clock, sync reset.
// Notes: Bound after the module.
`timescale 1ns/10ps
`default_nettype none
module icu_props
  import capture_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [NUM_CH-1:0] capture_input_pin_i,
  input wire logic low_power_i,
  input wire logic wake_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [NUM_CH-1:0] pin_q;
  logic [2:0] since;
  // Cycles since a pin last changed, saturating.
  always_ff @(posedge clk_i) begin
    pin_q <= capture_input_pin_i;
    if (rst_i) since <= 3'h7;
    else if (pin_q != capture_input_pin_i) since <= 3'h0;
    else if (since != 3'h7) since <= since + 3'h1;
  end
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence one_ack_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_latency_a: assert property (req_s |=> one_ack_s)
    else $error("ack late or long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data moved without ack");
  wake_lp_a: assert property (wake_o |-> $past(low_power_i))
    else $error("wake while awake");
  wake_pin_a: assert property (wake_o |-> since <= 3'h5)
    else $error("wake without pin edge");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
    else $error("irq dropped without write");
  irq_rise_a: assert property ($rose(irq_o) |->
    since <= 3'h5 || $past(wb_cyc_i && wb_stb_i && wb_we_i))
    else $error("irq rose without cause");
  quiet_reset_a: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o && !wake_o)
    else $error("outputs busy after reset");
endmodule
bind input_capture_unit icu_props icu_props_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_dat_o, .wb_ack_o, .capture_input_pin_i, .low_power_i, .wake_o, .irq_o);
`default_nettype wire

// [bench/pin_source.sv]
// Purpose: External signal on the capture pins.
// Assumes: Pulses last several clocks.
// Notes: Pins idle low.
`timescale 1ns/10ps
`default_nettype none
module pin_source
  import capture_pkg::*;
(
  input wire logic clk_i,
  output logic [NUM_CH-1:0] pin_o
);
  initial pin_o = '0;
  // Both levels stand long enough for the synchroniser and the store to land.
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge clk_i) pin_o[ch] <= 1'b1;
      repeat (3) @(posedge clk_i);
      pin_o[ch] <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
// Purpose: Self-checking bench for the capture unit.
// Assumes: Ack follows each request.
// Notes: Timers stand still during captures.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import capture_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, lp = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat, dat_o;
  logic [15:0] ta = 16'hA5A5, tbv = 16'h5A5A;
  logic [NUM_CH-1:0] pins;
  logic ack, wake, irq, woke = 1'b0;
  int mismatches = 0, checks_done = 0;
  int cnt[5] = '{1, 1, 1, 7, 17};
  int lvl[5] = '{1, 1, 2, 1, 1};
  cap_mode_t modes[5] = '{MODE_FALL, MODE_RISE, MODE_BOTH, MODE_DIV4, MODE_DIV16};
  input_capture_unit input_capture_unit_inst (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(4'hF), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .capture_input_pin_i(pins), .time_base_a_i(ta), .time_base_b_i(tbv),
    .low_power_i(lp), .wake_o(wake), .irq_o(irq));
  pin_source pin_source_inst (.clk_i, .pin_o(pins));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (wake) woke <= 1'b1;
  task automatic check(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rdat, exp);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(REG_IRQ_STATUS, 32'h0000_0000);
    rd_chk(8'h1C, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, i[0] ? REG_CTRL1 : REG_CTRL0, {27'h000_0000, i[0], 1'b0, modes[i]});
      pin_source_inst.pulse(i[0], cnt[i]);
      rd_chk(REG_LEVEL, lvl[i] << (8 * i[0]));
      repeat (lvl[i]) rd_chk(i[0] ? REG_DATA1 : REG_DATA0, i[0] ? tbv : ta);
      $display("mode test %0d done", i);
    end
    check(woke, 1'b0);
    rd_chk(REG_IRQ_STATUS, 32'h0000_0003);
    bus(1'b1, REG_IRQ_STATUS, 32'h0000_000F);
    bus(1'b1, REG_CTRL0, 32'h0000_0062);
    rd_chk(REG_CTRL0, 32'h0000_0062);
    lp <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      ta <= 16'h0100 + k[15:0];
      pin_source_inst.pulse(0, 1);
    end
    rd_chk(REG_IRQ_STATUS, 32'h0000_0005);
    check(irq, 1'b0);
    bus(1'b1, REG_IRQ_MASK, 32'h0000_0001);
    check(irq, 1'b1);
    check(woke, 1'b1);
    rd_chk(REG_LEVEL, 32'h0000_0004);
    for (int k = 0; k < 4; k++) rd_chk(REG_DATA0, 32'h0000_0100 + k);
    rd_chk(REG_LEVEL, 32'h0000_0000);
    bus(1'b1, REG_IRQ_STATUS, 32'h0000_0005);
    check(irq, 1'b0);
    $display("buffer test done");
    give_verdict();
  end
endmodule
`default_nettype wire
